// ---- core/sptx_enc8b10b.v ----
`timescale 1ns/100ps
module sptx_enc8b10b (
    byte_in,
    is_k,
    rd_in,
    code_out,
    rd_out
);
    input wire [7:0] byte_in;
    input wire is_k;
    input wire rd_in;
    output reg [9:0] code_out;
    output reg rd_out;

    // 5b/6b, negative disparity form, a in bit 5
    function [5:0] tab6;
        input [4:0] x;
        begin
            case (x)
                5'd0: tab6 = 6'b100111;
                5'd1: tab6 = 6'b011101;
                5'd2: tab6 = 6'b101101;
                5'd3: tab6 = 6'b110001;
                5'd4: tab6 = 6'b110101;
                5'd5: tab6 = 6'b101001;
                5'd6: tab6 = 6'b011001;
                5'd7: tab6 = 6'b111000;
                5'd8: tab6 = 6'b111001;
                5'd9: tab6 = 6'b100101;
                5'd10: tab6 = 6'b010101;
                5'd11: tab6 = 6'b110100;
                5'd12: tab6 = 6'b001101;
                5'd13: tab6 = 6'b101100;
                5'd14: tab6 = 6'b011100;
                5'd15: tab6 = 6'b010111;
                5'd16: tab6 = 6'b011011;
                5'd17: tab6 = 6'b100011;
                5'd18: tab6 = 6'b010011;
                5'd19: tab6 = 6'b110010;
                5'd20: tab6 = 6'b001011;
                5'd21: tab6 = 6'b101010;
                5'd22: tab6 = 6'b011010;
                5'd23: tab6 = 6'b111010;
                5'd24: tab6 = 6'b110011;
                5'd25: tab6 = 6'b100110;
                5'd26: tab6 = 6'b010110;
                5'd27: tab6 = 6'b110110;
                5'd28: tab6 = 6'b001110;
                5'd29: tab6 = 6'b101110;
                5'd30: tab6 = 6'b011110;
                default: tab6 = 6'b101011;
            endcase
        end
    endfunction

    // 3b/4b, negative disparity form, f in bit 3
    function [3:0] tab4;
        input [2:0] y;
        begin
            case (y)
                3'd0: tab4 = 4'b1011;
                3'd1: tab4 = 4'b1001;
                3'd2: tab4 = 4'b0101;
                3'd3: tab4 = 4'b1100;
                3'd4: tab4 = 4'b1101;
                3'd5: tab4 = 4'b1010;
                3'd6: tab4 = 4'b0110;
                default: tab4 = 4'b1110;
            endcase
        end
    endfunction

    function [2:0] ones6;
        input [5:0] v;
        begin
            ones6 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]} + {2'b00, v[4]} + {2'b00, v[5]};
        end
    endfunction

    function [2:0] ones4;
        input [3:0] v;
        begin
            ones4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
        end
    endfunction

    reg [4:0] x;
    reg [2:0] y;
    reg k28;
    reg [5:0] s6;
    reg [3:0] s4;
    reg rd1;
    reg alt7;

    // rd_in high means positive running disparity
    always @*
    begin
        x = byte_in[4:0];
        y = byte_in[7:5];
        k28 = is_k && (x == 5'd28);
        s6 = k28 ? 6'b001111 : tab6(x);
        if (rd_in && ((ones6(s6) != 3'd3) || (x == 5'd7 && !k28)))
            s6 = ~s6;
        rd1 = rd_in ^ (ones6(s6) != 3'd3);
        alt7 = (y == 3'd7) && ((is_k && !k28) ||
               (!rd1 && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
               (rd1 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
        s4 = alt7 ? 4'b0111 : tab4(y);
        if (k28 && y == 3'd7)
            s4 = 4'b0111;
        if (rd1 && ((ones4(s4) != 3'd2) || (y == 3'd3)))
            s4 = ~s4;
        else if (k28 && !rd1 && ones4(s4) == 3'd2)
            s4 = ~s4;
        rd_out = rd1 ^ (ones4(s4) != 3'd2);
        code_out = {s4[0], s4[1], s4[2], s4[3], s6[0], s6[1], s6[2], s6[3], s6[4], s6[5]};
    end
endmodule

// ---- core/sptx_regs.vh ----
`ifndef SPTX_REGS_VH
`define SPTX_REGS_VH

// register byte offsets
`define SPTX_CTRL_OFS 8'h00
`define SPTX_STAT_OFS 8'h04
`define SPTX_IRQ_STAT_OFS 8'h08
`define SPTX_IRQ_MASK_OFS 8'h0c
`define SPTX_LAST_CHAR_OFS 8'h10

// control fields
`define SPTX_CTRL_ENC_BIT 0
`define SPTX_CTRL_CKSEL_BIT 1
`define SPTX_CTRL_RATE_BIT 2
`define SPTX_CTRL_PABRST_BIT 3
`define SPTX_CTRL_RESET 4'h9

// status fields
`define SPTX_STAT_ERR_BIT 0
`define SPTX_STAT_INIT_BIT 1
`define SPTX_STAT_SYNC_BIT 2

// interrupt fields
`define SPTX_IRQ_ERR_SET_BIT 0
`define SPTX_IRQ_ERR_CLR_BIT 1
`define SPTX_IRQ_SYNC_DONE_BIT 2
`define SPTX_IRQ_W 3

// character type codes on the control pair
`define SPTX_CT_DATA 2'h0
`define SPTX_CT_FILL 2'h1
`define SPTX_CT_SPECIAL 2'h2
`define SPTX_CT_SYNC 2'h3

// word sync final count (sixteenth character) and reversed positions
`define SPTX_SYNC_LEN 4'hf
`define SPTX_SYNC_REV_A 4'h1
`define SPTX_SYNC_REV_B 4'h2

// fill character byte (K28.5) and violation character
`define SPTX_K28_5_BYTE 8'hbc
`define SPTX_VIOL_CHAR 10'h2f8

`endif

// ---- core/sptx_sync3.v ----
`timescale 1ns/100ps
module sptx_sync3 #(
    parameter WIDTH = 1
) (
    pclk,
    presetn,
    d,
    q
);
    input wire pclk;
    input wire presetn;
    input wire [WIDTH-1:0] d;
    output reg [WIDTH-1:0] q;

    reg [WIDTH-1:0] ff1_reg;
    reg [WIDTH-1:0] ff2_reg;
    reg [WIDTH-1:0] ff3_reg;
    integer i;

    // a bit changes only once stages two and three agree
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ff1_reg <= {WIDTH{1'b0}};
            ff2_reg <= {WIDTH{1'b0}};
            ff3_reg <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end
        else
        begin
            ff1_reg <= d;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            for (i = 0; i < WIDTH; i = i + 1)
            begin
                if (ff2_reg[i] == ff3_reg[i])
                    q[i] <= ff3_reg[i];
            end
        end
    end
endmodule

// ---- core/sptx_top.v ----
// What this block does
// (R1) encoding on: eight data and two control bits captured together each rising input clock edge
// (R2) bypass: control pair forms raw bits 8 and 9 above data bits 0..7
// (R3) host clock selected: captured characters pass through the phase-align buffer
// (R4) reference clock selected: buffer skipped, characters go straight to the encoder
// (R5) host clock may wander half a character period after buffer initialisation
// (R6) buffer overflow or underflow raises error output until buffer re-initialised
// (R7) writing zero to the buffer reset latch re-initialises the buffer phase
// (R8) while buffer error is active, the violation character is sent continuously
// (R9) word sync code during buffer error re-centres buffer and clears error
// (R10) host should follow each buffer reset with a full word sync sequence
// (R11) one 10-bit character leaves the encoder stage per character clock
// (R12) encoder latch at 1: 8B/10B coding with running disparity
// (R13) control pair decoded with data bits to select the transmission character
// (R14) two non-overlapping special code tables may map to the same character
// (R15) each character is handed to the shifter and sent least significant bit first
// (R16) bypass: captured character reaches the shifter unaltered, no control effect
// (R17) control pair 00 data, 01 fill, 10 special, 11 word sync sequence
// (R18) word sync runs sixteen characters uninterrupted, input ignored, restarts if sampled again
// (R19) after reset disparity is negative and buffer waits uninitialised for latch write
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`include "sptx_regs.vh"
module sptx_top #(
    parameter PAB_DEPTH = 4,
    parameter PTR_W = 2
) (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    host_tx_input_clock,
    channel_reference_clock,
    tx_char_data_in,
    tx_char_ctrl_in,
    tx_char_out,
    tx_char_strobe,
    tx_serial_out,
    tx_phase_error_out,
    irq_out
);
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [7:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    input wire host_tx_input_clock;
    input wire channel_reference_clock;
    input wire [7:0] tx_char_data_in;
    input wire [1:0] tx_char_ctrl_in;
    output reg [9:0] tx_char_out;
    output reg tx_char_strobe;
    output wire tx_serial_out;
    output reg tx_phase_error_out;
    output wire irq_out;

    // pin synchronisers
    wire [9:0] pin_char;
    wire host_clk_s;
    wire ref_clk_s;
    sptx_sync3 #(.WIDTH(10)) u_sync_char (
        .pclk(pclk),
        .presetn(presetn),
        .d({tx_char_ctrl_in, tx_char_data_in}),
        .q(pin_char)
    );
    sptx_sync3 #(.WIDTH(2)) u_sync_clk (
        .pclk(pclk),
        .presetn(presetn),
        .d({channel_reference_clock, host_tx_input_clock}),
        .q({ref_clk_s, host_clk_s})
    );

    reg host_clk_d_reg;
    reg ref_clk_d_reg;
    reg [3:0] ctrl_reg;
    reg [`SPTX_IRQ_W-1:0] irq_stat_reg;
    reg [`SPTX_IRQ_W-1:0] irq_mask_reg;
    reg [9:0] pab_mem_reg [0:PAB_DEPTH-1];
    reg [PTR_W-1:0] wptr_reg;
    reg [PTR_W-1:0] rptr_reg;
    reg [PTR_W:0] count_reg;
    reg init_done_reg;
    reg prime_reg;
    reg rd_reg;
    reg sync_active_reg;
    reg [3:0] sync_cnt_reg;
    reg [9:0] shift_reg;

    wire enc_on = ctrl_reg[`SPTX_CTRL_ENC_BIT];
    wire cksel = ctrl_reg[`SPTX_CTRL_CKSEL_BIT];
    wire rate = ctrl_reg[`SPTX_CTRL_RATE_BIT];
    wire host_edge = host_clk_s && !host_clk_d_reg;
    wire ref_rise = ref_clk_s && !ref_clk_d_reg;
    wire ref_fall = !ref_clk_s && ref_clk_d_reg;
    // half-rate reference makes a character on both edges
    wire char_tick = ref_rise || (rate && ref_fall);

    // apb decode, zero wait states
    wire apb_access = psel && penable;
    wire apb_wr = apb_access && pwrite;
    wire addr_ok = (paddr == `SPTX_CTRL_OFS) || (paddr == `SPTX_STAT_OFS) || (paddr == `SPTX_IRQ_STAT_OFS) ||
                   (paddr == `SPTX_IRQ_MASK_OFS) || (paddr == `SPTX_LAST_CHAR_OFS);
    assign pready = 1'b1;
    assign pslverr = apb_access && !addr_ok;
    wire ctrl_wr = apb_wr && (paddr == `SPTX_CTRL_OFS);
    wire pab_init = ctrl_wr && !pwdata[`SPTX_CTRL_PABRST_BIT]; // R7

    // buffer push and pop
    wire use_pab = !cksel; // R3 R4
    wire push = use_pab && host_edge;
    wire pop_req = use_pab && char_tick && init_done_reg && !prime_reg && !tx_phase_error_out;
    wire overflow = push && init_done_reg && !tx_phase_error_out && !pop_req && (count_reg == PAB_DEPTH);
    wire underflow = use_pab && char_tick && init_done_reg && !prime_reg && !tx_phase_error_out &&
                     (count_reg == {(PTR_W+1){1'b0}});
    wire pop = pop_req && (count_reg != {(PTR_W+1){1'b0}});
    // a sync code arriving during an error re-centres the buffer
    wire err_sync = push && tx_phase_error_out && enc_on && (pin_char[9:8] == `SPTX_CT_SYNC); // R9
    wire err_set = overflow || underflow; // R6
    wire err_clr = pab_init || err_sync;
    wire push_ok = push && init_done_reg && !tx_phase_error_out && !overflow;

    // character source for this tick
    reg src_valid;
    reg [9:0] src_char;
    always @*
    begin
        src_valid = 1'b0;
        src_char = pin_char;
        if (!use_pab)
        begin
            src_valid = char_tick; // R4
        end
        else if (pop)
        begin
            src_valid = 1'b1;
            src_char = pab_mem_reg[rptr_reg];
        end
    end

    // special character tables: low index set and the native K byte set
    reg sp_ok;
    reg [7:0] sp_byte;
    always @*
    begin
        sp_ok = 1'b1;
        case (src_char[7:0]) // R14
            8'h00, 8'h1c: sp_byte = 8'h1c;
            8'h01, 8'h3c: sp_byte = 8'h3c;
            8'h02, 8'h5c: sp_byte = 8'h5c;
            8'h03, 8'h7c: sp_byte = 8'h7c;
            8'h04, 8'h9c: sp_byte = 8'h9c;
            8'h05, 8'hbc: sp_byte = 8'hbc;
            8'h06, 8'hdc: sp_byte = 8'hdc;
            8'h07, 8'hfc: sp_byte = 8'hfc;
            8'h08, 8'hf7: sp_byte = 8'hf7;
            8'h09, 8'hfb: sp_byte = 8'hfb;
            8'h0a, 8'hfd: sp_byte = 8'hfd;
            8'h0b, 8'hfe: sp_byte = 8'hfe;
            default:
            begin
                sp_ok = 1'b0;
                sp_byte = 8'h00;
            end
        endcase
    end

    // character selection
    reg [7:0] enc_byte;
    reg enc_k;
    reg enc_rd_in;
    reg use_enc;
    reg [9:0] fixed_char;
    reg start_sync;
    reg sync_rev;
    always @*
    begin
        enc_byte = `SPTX_K28_5_BYTE;
        enc_k = 1'b1;
        use_enc = 1'b1;
        fixed_char = `SPTX_VIOL_CHAR;
        start_sync = 1'b0;
        sync_rev = 1'b0;
        if (sync_active_reg)
        begin
            sync_rev = (sync_cnt_reg == `SPTX_SYNC_REV_A) || (sync_cnt_reg == `SPTX_SYNC_REV_B); // R18
        end
        else if (use_pab && tx_phase_error_out)
        begin
            use_enc = 1'b0; // R8
        end
        else if (!src_valid)
        begin
            enc_k = 1'b1; // R10
        end
        else if (!enc_on)
        begin
            use_enc = 1'b0;
            fixed_char = src_char; // R2 R16
        end
        else
        begin
            case (src_char[9:8]) // R13 R17
                `SPTX_CT_DATA:
                begin
                    enc_byte = src_char[7:0]; // R12
                    enc_k = 1'b0;
                end
                `SPTX_CT_FILL: enc_k = 1'b1;
                `SPTX_CT_SPECIAL:
                begin
                    enc_byte = sp_byte;
                    use_enc = sp_ok;
                end
                `SPTX_CT_SYNC: start_sync = 1'b1;
                default: enc_k = 1'b1;
            endcase
        end
        enc_rd_in = rd_reg ^ sync_rev;
    end

    wire [9:0] enc_code;
    wire enc_rd_out;
    sptx_enc8b10b u_enc (
        .byte_in(enc_byte),
        .is_k(enc_k),
        .rd_in(enc_rd_in),
        .code_out(enc_code),
        .rd_out(enc_rd_out)
    );

    wire sync_last = sync_active_reg && (sync_cnt_reg == `SPTX_SYNC_LEN);
    wire sync_again = src_valid && enc_on && (src_char[9:8] == `SPTX_CT_SYNC);

    // character stage, one character per tick
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_clk_d_reg <= 1'b0;
            ref_clk_d_reg <= 1'b0;
            rd_reg <= 1'b0; // R19
            sync_active_reg <= 1'b0;
            sync_cnt_reg <= 4'h0;
            tx_char_out <= 10'h000;
            tx_char_strobe <= 1'b0;
            shift_reg <= 10'h000;
        end
        else
        begin
            host_clk_d_reg <= host_clk_s;
            ref_clk_d_reg <= ref_clk_s;
            tx_char_strobe <= char_tick; // R11
            if (char_tick)
            begin
                tx_char_out <= use_enc ? enc_code : fixed_char;
                shift_reg <= use_enc ? enc_code : fixed_char; // R15
                if (use_enc)
                    rd_reg <= enc_rd_out ^ sync_rev;
                if (sync_active_reg)
                begin
                    // input ignored until the sixteenth character, restart if sync seen then
                    sync_active_reg <= !sync_last || sync_again; // R18
                    sync_cnt_reg <= sync_last ? 4'h1 : sync_cnt_reg + 4'h1;
                    if (sync_last && !sync_again)
                        sync_cnt_reg <= 4'h0;
                end
                else if (start_sync)
                begin
                    sync_active_reg <= 1'b1;
                    sync_cnt_reg <= 4'h1;
                end
            end
            else
            begin
                shift_reg <= {1'b0, shift_reg[9:1]}; // R15
            end
        end
    end
    assign tx_serial_out = shift_reg[0];

    // phase-align buffer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr_reg <= {PTR_W{1'b0}};
            rptr_reg <= {PTR_W{1'b0}};
            count_reg <= {(PTR_W+1){1'b0}};
            init_done_reg <= 1'b0; // R19
            prime_reg <= 1'b1;
            tx_phase_error_out <= 1'b0;
        end
        else
        begin
            if (err_set)
                tx_phase_error_out <= 1'b1; // R6
            else if (err_clr)
                tx_phase_error_out <= 1'b0;
            if (pab_init || (err_sync && !err_set))
            begin
                // restart with reads held until half full so the host clock may wander both ways
                init_done_reg <= 1'b1; // R5 R7 R9
                prime_reg <= 1'b1;
                rptr_reg <= {PTR_W{1'b0}};
                wptr_reg <= err_sync ? {{(PTR_W-1){1'b0}}, 1'b1} : {PTR_W{1'b0}};
                count_reg <= err_sync ? {{PTR_W{1'b0}}, 1'b1} : {(PTR_W+1){1'b0}};
            end
            else
            begin
                if (push_ok)
                    wptr_reg <= wptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
                if (pop)
                    rptr_reg <= rptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
                if (push_ok && !pop)
                    count_reg <= count_reg + {{PTR_W{1'b0}}, 1'b1};
                else if (pop && !push_ok)
                    count_reg <= count_reg - {{PTR_W{1'b0}}, 1'b1};
                if (prime_reg && count_reg >= (PAB_DEPTH / 2))
                    prime_reg <= 1'b0;
            end
        end
    end

    always @(posedge pclk)
    begin
        if (push_ok || err_sync)
            pab_mem_reg[(err_sync && !err_set) ? {PTR_W{1'b0}} : wptr_reg] <= pin_char; // R1 R3
    end

    // registers and interrupts
    wire [`SPTX_IRQ_W-1:0] irq_ev = {sync_last && char_tick && !sync_again,
                                     err_clr && tx_phase_error_out && !err_set, err_set};
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `SPTX_CTRL_RESET;
            irq_stat_reg <= {`SPTX_IRQ_W{1'b0}};
            irq_mask_reg <= {`SPTX_IRQ_W{1'b0}};
        end
        else
        begin
            if (ctrl_wr)
                ctrl_reg <= pwdata[3:0];
            if (apb_wr && paddr == `SPTX_IRQ_MASK_OFS)
                irq_mask_reg <= pwdata[`SPTX_IRQ_W-1:0];
            if (apb_wr && paddr == `SPTX_IRQ_STAT_OFS)
                irq_stat_reg <= (irq_stat_reg & ~pwdata[`SPTX_IRQ_W-1:0]) | irq_ev;
            else
                irq_stat_reg <= irq_stat_reg | irq_ev;
        end
    end
    assign irq_out = |(irq_stat_reg & irq_mask_reg);

    // read data registered in the setup cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `SPTX_CTRL_OFS: prdata <= {28'h000_0000, ctrl_reg};
                `SPTX_STAT_OFS: prdata <= {21'h00_0000, count_reg, 4'h0, 1'b0, sync_active_reg,
                                           init_done_reg, tx_phase_error_out};
                `SPTX_IRQ_STAT_OFS: prdata <= {29'h0000_0000, irq_stat_reg};
                `SPTX_IRQ_MASK_OFS: prdata <= {29'h0000_0000, irq_mask_reg};
                `SPTX_LAST_CHAR_OFS: prdata <= {22'h00_0000, tx_char_out};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ---- tb/sptx_host_model.sv ----
`timescale 1ns/100ps
module sptx_host_model (
    input wire run,
    input wire [7:0] next_data,
    input wire [1:0] next_ctrl,
    output reg host_tx_input_clock,
    output reg [7:0] tx_char_data_in,
    output reg [1:0] tx_char_ctrl_in
);
    initial
    begin
        host_tx_input_clock = 1'b0;
        tx_char_data_in = 8'h00;
        tx_char_ctrl_in = 2'h1;
    end
    // same rate as the reference, so the phase never wanders; a stall parks the clock low
    always
    begin
        #62.5;
        if (run || host_tx_input_clock)
            host_tx_input_clock <= ~host_tx_input_clock;
    end
    // new character launched on the falling edge, held across the capturing rising edge
    always @(negedge host_tx_input_clock)
    begin
        tx_char_data_in <= next_data;
        tx_char_ctrl_in <= next_ctrl;
    end
endmodule

// ---- tb/sptx_monitor.sv ----
`timescale 1ns/100ps
`include "sptx_regs.vh"
module sptx_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [9:0] tx_char_out,
    input wire tx_char_strobe,
    input wire tx_serial_out,
    input wire tx_phase_error_out,
    input wire irq_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;
    a_strobe_single: assert property (tx_char_strobe |=> !tx_char_strobe)
        else $error("strobe longer than one cycle");
    a_char_held: assert property (!tx_char_strobe |-> $stable(tx_char_out))
        else $error("character changed without strobe");
    a_serial_lsb_first: assert property (tx_char_strobe |-> tx_serial_out == tx_char_out[0])
        else $error("first serial bit is not bit 0");
    a_serial_msb_last: assert property (tx_char_strobe |-> ##9 tx_serial_out == tx_char_out[9])
        else $error("tenth serial bit is not bit 9");
    a_serial_idle: assert property (tx_char_strobe |-> ##11 !tx_serial_out)
        else $error("serial line not idle after ten bits");
    a_viol_sent: assert property (tx_char_strobe && tx_phase_error_out && $past(tx_phase_error_out, 3)
        |-> tx_char_out == `SPTX_VIOL_CHAR)
        else $error("error active but violation character not sent");
    a_pab_reset_clears: assert property (wr && paddr == `SPTX_CTRL_OFS && !pwdata[`SPTX_CTRL_PABRST_BIT]
        |-> ##[1:2] !tx_phase_error_out)
        else $error("buffer reset did not clear error");
    a_irq_masked: assert property (wr && paddr == `SPTX_IRQ_MASK_OFS && pwdata[2:0] == 3'h0 |=> !irq_out)
        else $error("interrupt high with all sources masked");
endmodule

bind sptx_top sptx_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_char_out(tx_char_out), .tx_char_strobe(tx_char_strobe),
    .tx_serial_out(tx_serial_out), .tx_phase_error_out(tx_phase_error_out), .irq_out(irq_out));

// ---- tb/sptx_top_tb_top.sv ----
`timescale 1ns/100ps
`include "sptx_regs.vh"
module sptx_top_tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg ref_clk = 1'b0;
    reg run = 1'b1;
    reg [7:0] nd = 8'h00;
    reg [1:0] nc = 2'h1;
    wire [31:0] prdata;
    wire pready, pslverr, host_clk, tx_serial_out, err, irq, strobe;
    wire [7:0] tdata;
    wire [1:0] tctrl;
    wire [9:0] ch;
    integer fails = 0;
    integer num_checks = 0;
    integer i;
    integer n;
    reg [31:0] r;
    reg [9:0] c;
    reg [9:0] s;
    reg e;
    always #2.5 pclk = ~pclk;
    initial
    begin
        #50;
        forever #62.5 ref_clk <= ~ref_clk;
    end
    sptx_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_tx_input_clock(host_clk), .channel_reference_clock(ref_clk), .tx_char_data_in(tdata),
        .tx_char_ctrl_in(tctrl), .tx_char_out(ch), .tx_char_strobe(strobe), .tx_serial_out(tx_serial_out),
        .tx_phase_error_out(err), .irq_out(irq));
    sptx_host_model i_host (.run(run), .next_data(nd), .next_ctrl(nc), .host_tx_input_clock(host_clk),
        .tx_char_data_in(tdata), .tx_char_ctrl_in(tctrl));
    function k28(input [9:0] v);
        k28 = (v === 10'h17c) || (v === 10'h283);
    endfunction
    function dzero(input [9:0] v);
        dzero = (v === 10'h0b9) || (v === 10'h346);
    endfunction
    task summarize;
    begin
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task chk(input [127:0] what, input [31:0] exp, input [31:0] got);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
        end
    end
    endtask
    task chk_true(input [127:0] what, input ok);
    begin
        chk(what, 32'h1, {31'h0, ok});
    end
    endtask
    task xfer(input [7:0] a, input w, input [31:0] d);
    begin
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        if (pready !== 1'b1)
            fails = fails + 1;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
    endtask
    task next_char;
    begin
        n = 0;
        @(posedge pclk);
        while (strobe !== 1'b1 && n < 200)
        begin
            n = n + 1;
            @(posedge pclk);
        end
        if (strobe !== 1'b1)
            fails = fails + 1;
        c = ch;
    end
    endtask
    // one host cycle of the word sync code, then plain data
    task send_sync;
    begin
        nc <= 2'h3;
        @(negedge host_clk);
        @(posedge pclk);
        nc <= 2'h0;
    end
    endtask
    // length of the next run of fill characters, c holds the character after it
    task sync_run;
    begin
        i = 0;
        next_char;
        while (!k28(c) && i < 20)
        begin
            i = i + 1;
            next_char;
        end
        i = 0;
        while (k28(c) && i < 40)
        begin
            i = i + 1;
            next_char;
        end
    end
    endtask
    initial
    begin
        #200000;
        fails = fails + 1;
        summarize;
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(`SPTX_CTRL_OFS, 1'b0, 32'h0);
        chk("ctrl", {28'h0, `SPTX_CTRL_RESET}, r);
        xfer(`SPTX_STAT_OFS, 1'b0, 32'h0);
        chk("status", 32'h0, r & 32'h3);
        xfer(8'h40, 1'b0, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        xfer(`SPTX_CTRL_OFS, 1'b1, 32'ha);
        nd <= 8'h5a;
        nc <= 2'h2;
        repeat (4) next_char;
        chk("raw", 32'h25a, {22'h0, c});
        for (i = 0; i < 10; i = i + 1)
        begin
            s[i] = tx_serial_out;
            @(posedge pclk);
        end
        chk("serial", {22'h0, c}, {22'h0, s});
        xfer(`SPTX_CTRL_OFS, 1'b1, 32'hb);
        nc <= 2'h1;
        repeat (4) next_char;
        s = c;
        next_char;
        chk_true("fill", k28(s) && c === (s ^ 10'h3ff));
        nc <= 2'h0;
        nd <= 8'h00;
        repeat (4) next_char;
        chk_true("data", dzero(c));
        for (i = 0; i < 2; i = i + 1)
        begin
            nc <= 2'h2;
            nd <= i ? `SPTX_K28_5_BYTE : 8'h05;
            repeat (4) next_char;
            chk_true("special", k28(c));
        end
        nc <= 2'h0;
        nd <= 8'h00;
        xfer(`SPTX_CTRL_OFS, 1'b1, 32'h1);
        xfer(`SPTX_CTRL_OFS, 1'b1, 32'h9);
        send_sync;
        sync_run;
        chk_true("sync len", i >= 16);
        chk_true("buffered", dzero(c));
        chk("err", 32'h0, {31'h0, err});
        xfer(`SPTX_IRQ_MASK_OFS, 1'b1, 32'h1);
        run <= 1'b0;
        repeat (6) next_char;
        chk("viol", {22'h0, `SPTX_VIOL_CHAR}, {22'h0, c});
        chk("err", 32'h1, {31'h0, err});
        chk("irq", 32'h1, {31'h0, irq});
        xfer(`SPTX_IRQ_STAT_OFS, 1'b0, 32'h0);
        chk("irq stat", 32'h1, r & 32'h1);
        xfer(`SPTX_IRQ_MASK_OFS, 1'b1, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        xfer(`SPTX_IRQ_STAT_OFS, 1'b1, 32'h1);
        xfer(`SPTX_IRQ_STAT_OFS, 1'b0, 32'h0);
        chk("irq stat", 32'h0, r & 32'h1);
        run <= 1'b1;
        repeat (4) next_char;
        chk("err", 32'h1, {31'h0, err});
        send_sync;
        sync_run;
        chk_true("sync len", i >= 16);
        chk("err", 32'h0, {31'h0, err});
        chk_true("data", dzero(c));
        run <= 1'b0;
        repeat (6) next_char;
        chk("err", 32'h1, {31'h0, err});
        xfer(`SPTX_CTRL_OFS, 1'b1, 32'h1);
        chk("err", 32'h0, {31'h0, err});
        summarize;
    end
endmodule
